// ===== mies_defines.vh
`ifndef MIES_DEFINES_VH
`define MIES_DEFINES_VH
// operation codes presented by the decode stage
`define MIES_OP_NONE 5'h00
`define MIES_OP_DSZ 5'h01
`define MIES_OP_DSZA 5'h02
`define MIES_OP_ISZ 5'h03
`define MIES_OP_ISZA 5'h04
`define MIES_OP_SETB 5'h05
`define MIES_OP_SETBIT 5'h06
`define MIES_OP_SKIP_IF_NONZERO 5'h07
`define MIES_OP_SNZBIT 5'h08
`define MIES_OP_SKIP_IF_ZERO 5'h09
`define MIES_OP_SKIP_ZERO_COPY_ACC 5'h0A
`define MIES_OP_SZBIT 5'h0B
`define MIES_OP_SUB 5'h0C
`define MIES_OP_MINUS_INTO_MEM 5'h0D
`define MIES_OP_SUBI 5'h0E
`define MIES_OP_SWAP 5'h0F
`define MIES_OP_NIBBLE_EXCHANGE_TO_ACC 5'h10
`define MIES_OP_TRD 5'h11
`define MIES_OP_TRDL 5'h12
`define MIES_OP_ITRD 5'h13
`define MIES_OP_ITRDL 5'h14
`define MIES_OP_XOR 5'h15
`define MIES_OP_XOR_INTO_MEM 5'h16
`define MIES_OP_XORI 5'h17
// status flag positions
`define MIES_FLG_C 0
`define MIES_FLG_AUX_CARRY 1
`define MIES_FLG_Z 2
`define MIES_FLG_TWOS_COMPLEMENT_RANGE 3
`define MIES_FLG_SIGNED_COMPARISON 4
`define MIES_FLG_CHAINED_ZERO 5
// reset values
`define MIES_RST_ACC 8'h00
`define MIES_RST_FLAGS 6'h00
`define MIES_RST_PTR 8'h00
`define MIES_ALL_ONES 8'hFF
// cycles taken by a skip instruction
`define MIES_SKIP_CYCLES 2
`endif

// ===== mies_subtract.v
`timescale 1ns/1ps
`default_nettype none
`include "mies_defines.vh"
// 8-bit subtractor with the six arithmetic flags
module mies_subtract (
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_zero_prev,
  output wire [7:0] o_diff,
  output wire [5:0] o_flags
);
  wire [8:0] full; // nine-bit difference, bit 8 is borrow
  wire [4:0] low; // low-nibble difference, bit 4 is borrow
  wire ovf; // signed range exceeded
  assign full = {1'b0, i_a} - {1'b0, i_b};
  assign low = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]};
  assign o_diff = full[7:0];
  // overflow when operand signs differ and result sign follows b
  assign ovf = (i_a[7] ^ i_b[7]) & (full[7] ^ i_a[7]);
  // carry is not-borrow: clear only when i_b exceeds i_a as unsigned values
  assign o_flags[`MIES_FLG_C] = ~full[8];
  assign o_flags[`MIES_FLG_AUX_CARRY] = ~low[4];
  assign o_flags[`MIES_FLG_Z] = (full[7:0] == 8'h00);
  assign o_flags[`MIES_FLG_TWOS_COMPLEMENT_RANGE] = ovf;
  assign o_flags[`MIES_FLG_SIGNED_COMPARISON] = full[7] ^ ovf;
  // chained zero keeps the previous zero state across multi-byte chains
  assign o_flags[`MIES_FLG_CHAINED_ZERO] = (full[7:0] == 8'h00) & i_zero_prev;
endmodule
`default_nettype wire

// ===== mies_table_ptr.v
`timescale 1ns/1ps
`default_nettype none
`include "mies_defines.vh"
// table pointer pair and high-byte latch
module mies_table_ptr (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_incr,
  input wire i_wr_low,
  input wire i_wr_high,
  input wire [7:0] i_wdata,
  input wire i_latch_en,
  input wire [7:0] i_latch_data,
  output reg [7:0] o_table_ptr_low,
  output reg [7:0] o_table_ptr_high,
  output reg [7:0] o_table_high_latch
);
  // pointer and latch registers
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_table_ptr_low <= `MIES_RST_PTR;
      o_table_ptr_high <= `MIES_RST_PTR;
      o_table_high_latch <= `MIES_RST_PTR;
    end else begin
      if (i_incr) begin
        // low byte wraps, no carry into the high pointer
        o_table_ptr_low <= o_table_ptr_low + 8'h01;
      end else if (i_wr_low) begin
        o_table_ptr_low <= i_wdata;
      end
      if (i_wr_high) begin
        o_table_ptr_high <= i_wdata;
      end
      if (i_latch_en) begin
        o_table_high_latch <= i_latch_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== mies_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "mies_defines.vh"
// Overview of operation
// - decrement memory, write back, skip when zero
// - decrement into accumulator, skip when zero
// - increment memory, write back, skip when zero
// - increment into accumulator, skip when zero
// - skip instructions take two cycles each
// - byte set writes all ones
// - bit set forces one selected bit
// - skip when byte or bit nonzero
// - skip when whole byte is zero
// - copy byte to accumulator, skip when zero
// - skip when selected bit is zero
// - accumulator minus memory into accumulator, six flags
// - accumulator minus memory into memory, six flags
// - accumulator minus immediate, six flags
// - carry means no borrow on subtract
// - swap nibbles of memory in place
// - swapped nibbles go to accumulator only
// - table read using both pointers
// - table read last page using low pointer
// - increment low pointer, then paged table read
// - increment low pointer, then last-page read
// - xor into accumulator or memory, zero only
// - set, skip, swap, table leave flags
module mies_exec #(
  parameter PC_W = 15
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_start,
  input wire [4:0] i_op,
  input wire [2:0] i_bit,
  input wire [7:0] i_imm,
  input wire [7:0] i_mem_rdata,
  input wire [15:0] i_prog_rdata,
  input wire i_ptr_wr_low,
  input wire i_ptr_wr_high,
  input wire [7:0] i_ptr_wdata,
  output wire o_busy,
  output wire o_done,
  output reg o_skip,
  output reg o_mem_we,
  output reg [7:0] o_mem_wdata,
  output reg o_prog_re,
  output reg [PC_W-1:0] o_prog_addr,
  output reg [7:0] o_acc,
  output reg [5:0] o_flags,
  output wire [7:0] o_table_ptr_low,
  output wire [7:0] o_table_ptr_high,
  output wire [7:0] o_table_high_latch
);
  // sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_DUMMY = 2'b01;
  localparam ST_TABLE = 2'b10;
  localparam ST_TDATA = 2'b11;

  reg [1:0] state; // current sequencer state
  reg [1:0] next_state; // state for next edge
  reg [4:0] op_q; // opcode held during table reads
  reg [7:0] next_acc; // accumulator next value
  reg [5:0] next_flags; // flags next value
  reg next_mem_we; // memory write strobe next
  reg [7:0] next_mem_wdata; // memory write data next
  reg next_skip; // skip decision next
  reg next_prog_re; // program read strobe next
  reg [PC_W-1:0] next_prog_addr; // program address next
  reg ptr_incr; // low table pointer increment
  reg latch_en; // table high latch load
  reg [1:0] skip_cnt; // counts cycles of a skip instruction
  reg done_q; // completion pulse
  reg next_done; // completion next
  wire [7:0] dec_val; // memory minus one
  wire [7:0] inc_val; // memory plus one
  wire [7:0] swp_val; // nibbles exchanged
  wire [7:0] bit_mask; // one-hot selected bit
  wire [7:0] sub_b; // subtrahend mux
  wire [7:0] sub_diff; // subtractor result
  wire [5:0] sub_flags; // subtractor flags
  wire [7:0] xor_val; // xor result
  wire is_skip_op; // instruction can skip

  // one-hot bit mask decoder, shared by set and test
  function [7:0] onehot;
    input [2:0] sel;
    begin
      onehot = 8'h01 << sel;
    end
  endfunction

  // skip-class membership, evaluated once into is_skip_op
  function is_skip;
    input [4:0] op;
    begin
      is_skip = (op == `MIES_OP_DSZ) || (op == `MIES_OP_DSZA) ||
                (op == `MIES_OP_ISZ) || (op == `MIES_OP_ISZA) ||
                (op == `MIES_OP_SKIP_IF_NONZERO) || (op == `MIES_OP_SNZBIT) ||
                (op == `MIES_OP_SKIP_IF_ZERO) || (op == `MIES_OP_SKIP_ZERO_COPY_ACC) ||
                (op == `MIES_OP_SZBIT);
    end
  endfunction

  assign dec_val = i_mem_rdata - 8'h01;
  assign inc_val = i_mem_rdata + 8'h01;
  assign swp_val = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
  assign bit_mask = onehot(i_bit);
  assign xor_val = o_acc ^ ((i_op == `MIES_OP_XORI) ? i_imm : i_mem_rdata);
  assign sub_b = (i_op == `MIES_OP_SUBI) ? i_imm : i_mem_rdata;
  assign is_skip_op = is_skip(i_op);
  assign o_busy = (state != ST_IDLE);
  assign o_done = done_q;

  // shared subtractor
  mies_subtract u_sub (
    .i_a(o_acc),
    .i_b(sub_b),
    .i_zero_prev(o_flags[`MIES_FLG_Z]),
    .o_diff(sub_diff),
    .o_flags(sub_flags)
  );

  // table pointers and high latch
  mies_table_ptr u_tbl (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_incr(ptr_incr),
    .i_wr_low(i_ptr_wr_low),
    .i_wr_high(i_ptr_wr_high),
    .i_wdata(i_ptr_wdata),
    .i_latch_en(latch_en),
    .i_latch_data(i_prog_rdata[15:8]),
    .o_table_ptr_low(o_table_ptr_low),
    .o_table_ptr_high(o_table_ptr_high),
    .o_table_high_latch(o_table_high_latch)
  );

  // execute decode: next values of every result
  always @* begin
    next_state = state;
    next_acc = o_acc;
    next_flags = o_flags; // flags held unless an op changes them
    next_mem_we = 1'b0;
    next_mem_wdata = o_mem_wdata;
    next_skip = 1'b0;
    next_prog_re = 1'b0;
    next_prog_addr = o_prog_addr;
    next_done = 1'b0;
    ptr_incr = 1'b0;
    latch_en = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_start) begin
          next_done = ~is_skip_op;
          if (is_skip_op) begin
            // dummy cycle follows every skip-class op
            next_state = ST_DUMMY;
          end
          case (i_op)
            `MIES_OP_DSZ: begin
              next_mem_we = 1'b1; // write back decrement
              next_mem_wdata = dec_val;
              next_skip = (dec_val == 8'h00);
            end
            `MIES_OP_DSZA: begin
              next_acc = dec_val; // memory untouched
              next_skip = (dec_val == 8'h00);
            end
            `MIES_OP_ISZ: begin
              next_mem_we = 1'b1; // write back increment
              next_mem_wdata = inc_val;
              next_skip = (inc_val == 8'h00);
            end
            `MIES_OP_ISZA: begin
              next_acc = inc_val;
              next_skip = (inc_val == 8'h00);
            end
            `MIES_OP_SETB: begin
              next_mem_we = 1'b1;
              next_mem_wdata = `MIES_ALL_ONES;
            end
            `MIES_OP_SETBIT: begin
              next_mem_we = 1'b1;
              next_mem_wdata = i_mem_rdata | bit_mask;
            end
            `MIES_OP_SKIP_IF_NONZERO: begin
              next_skip = (i_mem_rdata != 8'h00);
            end
            `MIES_OP_SNZBIT: begin
              next_skip = |(i_mem_rdata & bit_mask);
            end
            `MIES_OP_SKIP_IF_ZERO: begin
              next_skip = (i_mem_rdata == 8'h00);
            end
            `MIES_OP_SKIP_ZERO_COPY_ACC: begin
              next_acc = i_mem_rdata;
              next_skip = (i_mem_rdata == 8'h00);
            end
            `MIES_OP_SZBIT: begin
              next_skip = ~|(i_mem_rdata & bit_mask);
            end
            `MIES_OP_SUB, `MIES_OP_SUBI: begin
              next_acc = sub_diff;
              next_flags = sub_flags; // not-borrow carry
            end
            `MIES_OP_MINUS_INTO_MEM: begin
              next_mem_we = 1'b1; // difference to memory
              next_mem_wdata = sub_diff;
              next_flags = sub_flags;
            end
            `MIES_OP_SWAP: begin
              next_mem_we = 1'b1;
              next_mem_wdata = swp_val;
            end
            `MIES_OP_NIBBLE_EXCHANGE_TO_ACC: begin
              next_acc = swp_val;
            end
            `MIES_OP_TRD, `MIES_OP_TRDL, `MIES_OP_ITRD, `MIES_OP_ITRDL: begin
              // pointer increment first for the pre-increment forms
              ptr_incr = (i_op == `MIES_OP_ITRD) ||
                         (i_op == `MIES_OP_ITRDL);
              next_done = 1'b0;
              next_state = ST_TABLE;
            end
            `MIES_OP_XOR, `MIES_OP_XORI: begin
              next_acc = xor_val;
              next_flags[`MIES_FLG_Z] = (xor_val == 8'h00);
            end
            `MIES_OP_XOR_INTO_MEM: begin
              next_mem_we = 1'b1;
              next_mem_wdata = xor_val;
              next_flags[`MIES_FLG_Z] = (xor_val == 8'h00);
            end
            default: begin
              next_done = 1'b0;
            end
          endcase
        end
      end
      ST_DUMMY: begin
        // second cycle of a skip op; skip strobe held
        next_skip = o_skip;
        // the last counted skip cycle closes the instruction
        if ((skip_cnt + 2'h1) == `MIES_SKIP_CYCLES) begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_TABLE: begin
        // issue program read with the current pointers
        next_prog_re = 1'b1;
        if ((op_q == `MIES_OP_TRDL) || (op_q == `MIES_OP_ITRDL)) begin
          // last page: only the low pointer
          next_prog_addr = {{(PC_W-8){1'b1}}, o_table_ptr_low};
        end else begin
          // both pointers
          next_prog_addr = {o_table_ptr_high[PC_W-9:0], o_table_ptr_low};
        end
        next_state = ST_TDATA;
      end
      ST_TDATA: begin
        // program word arrives: low to memory, high to latch
        next_mem_we = 1'b1;
        next_mem_wdata = i_prog_rdata[7:0];
        latch_en = 1'b1;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state and output registers
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      op_q <= `MIES_OP_NONE;
      o_acc <= `MIES_RST_ACC;
      o_flags <= `MIES_RST_FLAGS;
      o_mem_we <= 1'b0;
      o_mem_wdata <= 8'h00;
      o_skip <= 1'b0;
      o_prog_re <= 1'b0;
      o_prog_addr <= {PC_W{1'b0}};
      done_q <= 1'b0;
      skip_cnt <= 2'h0;
    end else begin
      state <= next_state;
      o_acc <= next_acc;
      o_flags <= next_flags;
      o_mem_we <= next_mem_we;
      o_mem_wdata <= next_mem_wdata;
      o_skip <= next_skip;
      o_prog_re <= next_prog_re;
      o_prog_addr <= next_prog_addr;
      done_q <= next_done;
      if ((state == ST_IDLE) && i_start) begin
        op_q <= i_op;
      end
      // cycle count of skip-class ops, two in all
      if ((state == ST_IDLE) && i_start && is_skip_op) begin
        skip_cnt <= 2'h1;
      end else if ((skip_cnt != 2'h0) && (skip_cnt < `MIES_SKIP_CYCLES)) begin
        skip_cnt <= skip_cnt + 2'h1;
      end else begin
        skip_cnt <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== mies_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mies_defines.vh"
// port-level relations of the execute unit
module mies_exec_properties #(
  parameter PC_W = 15
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [4:0] i_op,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [15:0] i_prog_rdata,
  input wire logic i_ptr_wr_low,
  input wire logic i_ptr_wr_high,
  input wire logic [7:0] i_ptr_wdata,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_skip,
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_prog_re,
  input wire logic [PC_W-1:0] o_prog_addr,
  input wire logic [7:0] o_acc,
  input wire logic [5:0] o_flags,
  input wire logic [7:0] o_table_ptr_low,
  input wire logic [7:0] o_table_ptr_high,
  input wire logic [7:0] o_table_high_latch
);
  // instruction accepted on this edge
  wire take = i_start && !o_busy;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // both skip cycles flagged, done on the second
  sequence skip_pair;
    o_skip ##1 (o_skip && o_done);
  endsequence
  // two cycles without a discard
  sequence no_skip;
    !o_skip ##1 (!o_skip && o_done);
  endsequence
  // read strobe, then write of the low byte with done
  sequence table_walk;
    ##1 o_prog_re ##1 (o_mem_we && o_done);
  endsequence
  sz_skip_a: assert property (
    take && i_op == `MIES_OP_SKIP_IF_ZERO && i_mem_rdata == 8'h00 |=> skip_pair)
    else $error("zero byte test did not skip");
  sz_keep_a: assert property (
    take && i_op == `MIES_OP_SKIP_IF_ZERO && i_mem_rdata != 8'h00 |=> no_skip)
    else $error("nonzero byte test skipped or wrong length");
  nz_skip_a: assert property (
    take && i_op == `MIES_OP_SKIP_IF_NONZERO && i_mem_rdata != 8'h00 |=> skip_pair)
    else $error("nonzero test did not skip");
  bit_zero_a: assert property (
    take && i_op == `MIES_OP_SZBIT && !i_mem_rdata[i_bit] |=> skip_pair)
    else $error("clear bit test did not skip");
  dec_skip_a: assert property (
    take && i_op == `MIES_OP_DSZ |=> o_skip == ($past(i_mem_rdata) == 8'h01))
    else $error("decrement skip decision wrong");
  set_byte_a: assert property (
    take && i_op == `MIES_OP_SETB |=> o_mem_we && o_mem_wdata == 8'hFF)
    else $error("byte set wrote wrong value");
  set_bit_a: assert property (
    take && i_op == `MIES_OP_SETBIT |=> o_mem_we &&
    o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << $past(i_bit))))
    else $error("bit set wrote wrong value");
  swap_mem_a: assert property (
    take && i_op == `MIES_OP_SWAP |=> o_mem_we && $stable(o_flags) &&
    o_mem_wdata == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])})
    else $error("nibble swap wrong");
  sub_carry_a: assert property (
    take && i_op == `MIES_OP_SUBI |=>
    o_flags[`MIES_FLG_C] == ($past(o_acc) >= $past(i_imm)))
    else $error("subtract carry wrong");
  table_seq_a: assert property (
    take && i_op inside {`MIES_OP_TRD, `MIES_OP_TRDL, `MIES_OP_ITRD, `MIES_OP_ITRDL}
    |=> table_walk)
    else $error("table read sequence wrong");
  last_page_a: assert property (
    take && i_op == `MIES_OP_TRDL |=>
    ##1 o_prog_addr == {{(PC_W-8){1'b1}}, o_table_ptr_low})
    else $error("last page address wrong");
endmodule
`default_nettype wire

// ===== mies_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
// program memory; the word stands only while the read strobe stands
module mies_prog_model #(
  parameter PC_W = 15
) (
  input wire logic i_prog_re,
  input wire logic [PC_W-1:0] i_prog_addr,
  output logic [15:0] o_prog_rdata
);
  logic [15:0] word; // word stored at the presented address
  assign word = {i_prog_addr[PC_W-1:PC_W-8], i_prog_addr[7:0] ^ 8'h5A};
  // answer a read, otherwise show the inverse so a stray capture shows up
  always_comb begin
    if (i_prog_re) begin
      o_prog_rdata = word;
    end else begin
      o_prog_rdata = ~word;
    end
  end
endmodule
`default_nettype wire

// ===== mies_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mies_defines.vh"
// runs every operation on boundary and random bytes
module mies_exec_tb_top;
  localparam PC_W = 15;
  // expected result of one instruction
  typedef struct packed {
    logic [7:0] acc; logic [5:0] flg; logic we; logic [7:0] wd;
    logic skp; logic [7:0] lat; logic [7:0] ph; logic [7:0] pl;
  } mies_exp_t;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic [4:0] i_op = 5'h00;
  logic [2:0] i_bit = 3'h0;
  logic [7:0] i_imm = 8'h00;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [7:0] i_ptr_wdata = 8'h00;
  logic i_ptr_wr_low = 1'b0;
  logic i_ptr_wr_high = 1'b0;
  wire [15:0] i_prog_rdata;
  wire o_busy, o_done, o_skip, o_mem_we, o_prog_re;
  wire [7:0] o_mem_wdata, o_acc, o_table_ptr_low, o_table_ptr_high, o_table_high_latch;
  wire [PC_W-1:0] o_prog_addr;
  wire [5:0] o_flags;
  mies_exp_t exp_q[$];
  mies_exp_t e;
  // reference state
  logic [7:0] acc_m = 8'h00, pl_m = 8'h00, ph_m = 8'h00, lat_m = 8'h00;
  logic [5:0] flg_m = 6'h00;
  logic seen_we = 1'b0, seen_skip = 1'b0;
  logic [7:0] seen_wd = 8'h00;
  int n_fail = 0;
  int check_count = 0;
  mies_exec #(.PC_W(PC_W)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op), .i_bit(i_bit),
    .i_imm(i_imm), .i_mem_rdata(i_mem_rdata), .i_prog_rdata(i_prog_rdata),
    .i_ptr_wr_low(i_ptr_wr_low), .i_ptr_wr_high(i_ptr_wr_high), .i_ptr_wdata(i_ptr_wdata),
    .o_busy(o_busy), .o_done(o_done), .o_skip(o_skip), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .o_prog_re(o_prog_re), .o_prog_addr(o_prog_addr),
    .o_acc(o_acc), .o_flags(o_flags), .o_table_ptr_low(o_table_ptr_low),
    .o_table_ptr_high(o_table_ptr_high), .o_table_high_latch(o_table_high_latch));
  mies_prog_model #(.PC_W(PC_W)) i_prog (.i_prog_re(o_prog_re),
    .i_prog_addr(o_prog_addr), .o_prog_rdata(i_prog_rdata));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // monitor: gather writes and skips, compare at done
  always @(negedge i_ref_clk) begin
    if (o_mem_we === 1'b1) begin
      seen_we = 1'b1;
      seen_wd = o_mem_wdata;
    end
    if (o_skip === 1'b1) seen_skip = 1'b1;
    if (o_done === 1'b1) begin
      e = exp_q.pop_front();
      check("acc", o_acc, e.acc);
      check("flags", o_flags, e.flg);
      check("write", {seen_we, seen_we ? seen_wd : 8'h00}, {e.we, e.wd});
      check("skip", seen_skip, e.skp);
      check("latch", o_table_high_latch, e.lat);
      check("ptrs", {o_table_ptr_high, o_table_ptr_low}, {e.ph, e.pl});
      seen_we = 1'b0;
      seen_skip = 1'b0;
    end
  end
  // compute the expectation, issue one instruction, wait for its end
  task automatic run(input logic [4:0] op, input logic [2:0] bt, input logic [7:0] imm, m);
    mies_exp_t x;
    logic [7:0] r, b;
    logic [14:0] a;
    int k;
    x = '0;
    r = m;
    b = (op == `MIES_OP_SUBI || op == `MIES_OP_XORI) ? imm : m;
    case (op)
      `MIES_OP_DSZ, `MIES_OP_DSZA: r = m - 8'h01;
      `MIES_OP_ISZ, `MIES_OP_ISZA: r = m + 8'h01;
      `MIES_OP_SETB: r = 8'hFF;
      `MIES_OP_SETBIT: r = m | (8'h01 << bt);
      `MIES_OP_SWAP, `MIES_OP_NIBBLE_EXCHANGE_TO_ACC: r = {m[3:0], m[7:4]};
      `MIES_OP_SUB, `MIES_OP_MINUS_INTO_MEM, `MIES_OP_SUBI: begin
        r = acc_m - b;
        // chained zero, signed less-than, overflow, zero, nibble and byte not-borrow
        flg_m = {(r == 8'h00) & flg_m[`MIES_FLG_Z], $signed(acc_m) < $signed(b),
          (acc_m[7] ^ b[7]) & (r[7] ^ acc_m[7]), r == 8'h00, acc_m[3:0] >= b[3:0], acc_m >= b};
      end
      `MIES_OP_XOR, `MIES_OP_XOR_INTO_MEM, `MIES_OP_XORI: begin
        r = acc_m ^ b;
        flg_m[`MIES_FLG_Z] = (r == 8'h00);
      end
      `MIES_OP_TRD, `MIES_OP_TRDL, `MIES_OP_ITRD, `MIES_OP_ITRDL: begin
        if (op == `MIES_OP_ITRD || op == `MIES_OP_ITRDL) pl_m = pl_m + 8'h01;
        a = (op == `MIES_OP_TRDL || op == `MIES_OP_ITRDL) ? {7'h7F, pl_m} : {ph_m[6:0], pl_m};
        r = a[7:0] ^ 8'h5A;
        lat_m = a[14:7];
      end
      default: r = m;
    endcase
    x.we = op inside {`MIES_OP_DSZ, `MIES_OP_ISZ, `MIES_OP_SETB, `MIES_OP_SETBIT,
      `MIES_OP_MINUS_INTO_MEM, `MIES_OP_SWAP, `MIES_OP_XOR_INTO_MEM, `MIES_OP_TRD,
      `MIES_OP_TRDL, `MIES_OP_ITRD, `MIES_OP_ITRDL};
    x.wd = x.we ? r : 8'h00;
    if (op inside {`MIES_OP_DSZA, `MIES_OP_ISZA, `MIES_OP_SKIP_ZERO_COPY_ACC, `MIES_OP_SUB,
      `MIES_OP_SUBI, `MIES_OP_NIBBLE_EXCHANGE_TO_ACC, `MIES_OP_XOR, `MIES_OP_XORI}) acc_m = r;
    case (op)
      `MIES_OP_DSZ, `MIES_OP_DSZA, `MIES_OP_ISZ, `MIES_OP_ISZA,
      `MIES_OP_SKIP_ZERO_COPY_ACC, `MIES_OP_SKIP_IF_ZERO:
        x.skp = (r == 8'h00);
      `MIES_OP_SKIP_IF_NONZERO: x.skp = (m != 8'h00);
      `MIES_OP_SNZBIT: x.skp = m[bt];
      `MIES_OP_SZBIT: x.skp = !m[bt];
      default: x.skp = 1'b0;
    endcase
    x.acc = acc_m;
    x.flg = flg_m;
    x.lat = lat_m;
    x.ph = ph_m;
    x.pl = pl_m;
    exp_q.push_back(x);
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    i_op <= op;
    i_bit <= bt;
    i_imm <= imm;
    i_mem_rdata <= m;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    for (k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge i_ref_clk);
    // a completion that never came counts against the run
    if (exp_q.size() != 0) begin
      check("done", 32'(exp_q.size()), 32'h0);
      exp_q.delete();
    end
    i_mem_rdata <= ~m;
  endtask
  // load low then high table pointer
  task automatic set_ptr(input logic [7:0] lo, hi);
    @(posedge i_ref_clk);
    i_ptr_wr_low <= 1'b1;
    i_ptr_wdata <= lo;
    @(posedge i_ref_clk);
    i_ptr_wr_low <= 1'b0;
    i_ptr_wr_high <= 1'b1;
    i_ptr_wdata <= hi;
    @(posedge i_ref_clk);
    i_ptr_wr_high <= 1'b0;
    i_ptr_wdata <= ~hi;
    pl_m = lo;
    ph_m = hi;
  endtask
  // main sequence: boundary bytes first, then random ones
  initial begin
    void'($urandom(32'hE4F4));
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    set_ptr(8'hFF, 8'h12);
    for (int n = 0; n < 6; n++) begin
      for (int op = 1; op < 24; op++) begin
        run(op[4:0], 3'($urandom), 8'($urandom),
          n == 0 ? 8'h00 : n == 1 ? 8'h01 : n == 2 ? 8'hFF : 8'($urandom));
      end
    end
    final_report;
  end
  // watchdog for a hung handshake
  initial begin
    #500000;
    n_fail++;
    final_report;
  end
endmodule
bind mies_exec mies_exec_properties #(.PC_W(PC_W)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op), .i_bit(i_bit),
  .i_imm(i_imm), .i_mem_rdata(i_mem_rdata), .i_prog_rdata(i_prog_rdata),
  .i_ptr_wr_low(i_ptr_wr_low), .i_ptr_wr_high(i_ptr_wr_high), .i_ptr_wdata(i_ptr_wdata),
  .o_busy(o_busy), .o_done(o_done), .o_skip(o_skip), .o_mem_we(o_mem_we),
  .o_mem_wdata(o_mem_wdata), .o_prog_re(o_prog_re), .o_prog_addr(o_prog_addr),
  .o_acc(o_acc), .o_flags(o_flags), .o_table_ptr_low(o_table_ptr_low),
  .o_table_ptr_high(o_table_ptr_high), .o_table_high_latch(o_table_high_latch));
`default_nettype wire
